//--- verilog/bffs_pkg.sv
// shared constants and types for the bus fault frame stacker
package bffs_pkg;
	typedef logic [4:0] bffs_off_t;

	typedef enum logic [1:0] {
		KIND_NORMAL,
		KIND_MULTI,
		KIND_EXC
	} bffs_kind_t;

	// captured fault context, one frame worth
	typedef struct packed {
		bffs_kind_t  kind;
		logic        six;
		logic        dyn;
		logic [15:0] sr;
		logic [31:0] ret_pc;
		logic [11:0] vec_off;
		logic [31:0] cyc_addr;
		logic [31:0] err_addr;
		logic [31:0] fault_data_buffer;
		logic [31:0] cur_pc;
		logic [15:0] pre_sr;
		logic [15:0] flt_fv;
		logic [7:0]  xfer_cnt;
		logic [13:0] ssw_lo;
	} bffs_fault_t;

	typedef struct packed {
		logic illegal;
		logic bkpt;
		logic aline;
		logic fline;
	} bffs_opcls_t;

	// byte offsets above the final stack pointer
	localparam bffs_off_t OFF_SR      = 5'h00;
	localparam bffs_off_t OFF_RPC_HI  = 5'h02;
	localparam bffs_off_t OFF_RPC_LO  = 5'h04;
	localparam bffs_off_t OFF_FMTVEC  = 5'h06;
	localparam bffs_off_t OFF_FA_HI   = 5'h08;
	localparam bffs_off_t OFF_FA_LO   = 5'h0A;
	localparam bffs_off_t OFF_FAULT_DATA_BUFFER_HI = 5'h0C;
	localparam bffs_off_t OFF_FAULT_DATA_BUFFER_LO = 5'h0E;
	localparam bffs_off_t OFF_CPC_HI  = 5'h10;
	localparam bffs_off_t OFF_CPC_LO  = 5'h12;
	localparam bffs_off_t OFF_COUNT   = 5'h14;
	localparam bffs_off_t OFF_SSW     = 5'h16;
	localparam bffs_off_t WORD_BYTES  = 5'h02;

	localparam logic [3:0]  FMT_BUS_FAULT = 4'hC;
	localparam logic [1:0]  TPMV_NORMAL   = 2'h0;
	localparam logic [1:0]  TPMV_MULTI    = 2'h1;
	localparam logic [1:0]  TPMV_EXC      = 2'h2;
	localparam logic [7:0]  MCODE_REV     = 8'h01;
	localparam logic [7:0]  CNT_NONE      = 8'h00;

	// opcode classes
	localparam logic [15:0] OP_BKPT_LO = 16'h4848;
	localparam logic [15:0] OP_BKPT_HI = 16'h484F;
	localparam logic [3:0]  LINE_A     = 4'hA;
	localparam logic [3:0]  LINE_F     = 4'hF;

	// trace mode select
	localparam logic [1:0] TRC_FLOW = 2'h1;
	localparam logic [1:0] TRC_ALL  = 2'h2;

	// exception vector numbers, plain defaults
	localparam logic [7:0] VEC_ILLEGAL = 8'h04;
	localparam logic [7:0] VEC_TRACE   = 8'h09;
	localparam logic [7:0] VEC_ALINE   = 8'h0A;
	localparam logic [7:0] VEC_FLINE   = 8'h0B;
endpackage : bffs_pkg

//--- verilog/bffs_opdec.sv
// opcode classifier for illegal, breakpoint and line-A/F exceptions
`timescale 1ns/1ns
module bffs_opdec (
	// opcode in
	input  wire logic [15:0]         opcode,
	input  wire logic                undef,
	// class out
	output bffs_pkg::bffs_opcls_t    cls
);
	import bffs_pkg::*;

	always_comb begin
		cls.aline = (opcode[15:12] == LINE_A);
		cls.fline = (opcode[15:12] == LINE_F);
		cls.bkpt  = (opcode >= OP_BKPT_LO) && (opcode <= OP_BKPT_HI);
		// breakpoints are illegal opcodes handled by the illegal vector
		cls.illegal = undef | cls.bkpt;
	end
endmodule : bffs_opdec

//--- verilog/bffs_stacker.sv
// bus fault frame stacker with trace and illegal-opcode exception requests
`timescale 1ns/1ns
// Functional notes
// - normal faults stack twelve-word frame in order
// - normal fault status word top bits 00
// - multi-move fault status word top bits 01
// - exception-time fault frame, status top bits 10
// - transfer count register at offset 14h, 10h in short exception-time frames
// - format code 1100 over vector offset
// - trace every completed instruction when enabled
// - optional trace only on flow changes
// - opcodes 4848h-484Fh are breakpoint illegals
// - illegal opcode takes illegal instruction exception
// - line A and F take own vectors
// - count word holds revision and move count
// - dynamic cycle faults record upper byte address
module bffs_stacker (
	// clock and reset
	input  wire logic                SYS_CLK,
	input  wire logic                RESETN,
	// fault request
	input  wire logic                FAULT_VALID,
	input  bffs_pkg::bffs_fault_t    FAULT_INFO,
	input  wire logic [31:0]         SP_IN,
	output logic                     BUSY,
	// stack write bus
	output logic                     WR_REQ,
	output logic [31:0]              WR_ADDR,
	output logic [15:0]              WR_DATA,
	input  wire logic                WR_ACK,
	// frame result
	output logic                     FRAME_DONE,
	output logic [31:0]              SP_OUT,
	// instruction stream
	input  wire logic                DEC_VALID,
	input  wire logic [15:0]         DEC_OPCODE,
	input  wire logic                DEC_UNDEF,
	input  wire logic                RETIRE,
	input  wire logic                FLOW_CHG,
	input  wire logic [1:0]          TRACE_MODE,
	// exception request
	output logic                     EXC_REQ,
	output logic [7:0]               EXC_VECTOR,
	output logic                     BKPT_HIT
);
	import bffs_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_DONE} bffs_state_t;

	bffs_state_t  state_ff;
	bffs_fault_t  info_ff;
	bffs_off_t    off_ff;
	bffs_off_t    last_ff;
	logic [31:0]  sp_ff;
	logic [31:0]  start_sp_ff;
	logic [31:0]  addr_ff;
	logic [15:0]  data_ff;
	bffs_opcls_t  cls;
	logic         dec_exc;
	logic         trace_hit;
	logic         trace_pend_ff;
	logic         exc_req_ff;
	logic [7:0]   exc_vec_ff;
	logic         bkpt_ff;

	// top written offset; a ten-word faulted frame has no instruction pc
	function automatic bffs_off_t top_off(input bffs_fault_t f);
		top_off = (f.kind == KIND_EXC && !f.six) ? OFF_CPC_LO : OFF_SSW;
	endfunction : top_off

	function automatic logic [15:0] frame_word(input bffs_off_t off, input bffs_fault_t f);
		logic [31:0] fa;
		logic [1:0]  tpmv;
		logic [15:0] cnt;
		logic        exc;
		bffs_off_t   o;
		exc = (f.kind == KIND_EXC);
		fa = f.dyn ? f.cyc_addr : f.err_addr;
		case (f.kind)
			KIND_MULTI: tpmv = TPMV_MULTI;
			KIND_EXC:   tpmv = TPMV_EXC;
			default:    tpmv = TPMV_NORMAL;
		endcase
		// move count is only meaningful for multi-move faults
		cnt = {MCODE_REV, (f.kind == KIND_MULTI) ? f.xfer_cnt : CNT_NONE};
		o = off;
		if (exc && !f.six) begin
			// short frame slides count and status word down one long word
			if (off == OFF_CPC_HI) begin
				o = OFF_COUNT;
			end else if (off == OFF_CPC_LO) begin
				o = OFF_SSW;
			end
		end
		case (o)
			OFF_SR:      frame_word = f.sr;
			OFF_RPC_HI:  frame_word = f.ret_pc[31:16];
			OFF_RPC_LO:  frame_word = f.ret_pc[15:0];
			OFF_FMTVEC:  frame_word = {FMT_BUS_FAULT, f.vec_off};
			OFF_FA_HI:   frame_word = fa[31:16];
			OFF_FA_LO:   frame_word = fa[15:0];
			OFF_FAULT_DATA_BUFFER_HI: frame_word = exc ? f.pre_sr : f.fault_data_buffer[31:16];
			OFF_FAULT_DATA_BUFFER_LO: frame_word = exc ? f.flt_fv : f.fault_data_buffer[15:0];
			OFF_CPC_HI:  frame_word = f.cur_pc[31:16];
			OFF_CPC_LO:  frame_word = f.cur_pc[15:0];
			OFF_COUNT:   frame_word = cnt;
			OFF_SSW:     frame_word = {tpmv, f.ssw_lo};
			default:     frame_word = 16'h0000;
		endcase
	endfunction : frame_word

	// stacking sequencer: highest offset first, so the status register lands lowest
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_ff <= ST_IDLE;
		end else begin
			case (state_ff)
				ST_IDLE:  if (FAULT_VALID) state_ff <= ST_WRITE;
				ST_WRITE: if (WR_ACK && off_ff == OFF_SR) state_ff <= ST_DONE;
				ST_DONE:  state_ff <= ST_IDLE;
				default:  state_ff <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			info_ff     <= '0;
			last_ff     <= OFF_SR;
			start_sp_ff <= 32'h0000_0000;
		end else if (state_ff == ST_IDLE && FAULT_VALID) begin
			info_ff     <= FAULT_INFO;
			last_ff     <= top_off(FAULT_INFO);
			start_sp_ff <= SP_IN;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			off_ff  <= OFF_SR;
			addr_ff <= 32'h0000_0000;
			data_ff <= 16'h0000;
			sp_ff   <= 32'h0000_0000;
		end else if (state_ff == ST_IDLE && FAULT_VALID) begin
			off_ff  <= top_off(FAULT_INFO);
			addr_ff <= SP_IN - 32'(WORD_BYTES);
			data_ff <= frame_word(top_off(FAULT_INFO), FAULT_INFO);
			sp_ff   <= SP_IN;
		end else if (state_ff == ST_WRITE && WR_ACK) begin
			sp_ff <= addr_ff;
			if (off_ff != OFF_SR) begin
				off_ff  <= off_ff - WORD_BYTES;
				addr_ff <= addr_ff - 32'(WORD_BYTES);
				data_ff <= frame_word(off_ff - WORD_BYTES, info_ff);
			end
		end
	end

	assign BUSY       = (state_ff != ST_IDLE);
	assign WR_REQ     = (state_ff == ST_WRITE);
	assign WR_ADDR    = addr_ff;
	assign WR_DATA    = data_ff;
	assign FRAME_DONE = (state_ff == ST_DONE);
	assign SP_OUT     = sp_ff;

	bffs_opdec u_opdec (
		.opcode (DEC_OPCODE),
		.undef  (DEC_UNDEF),
		.cls    (cls)
	);

	assign dec_exc = DEC_VALID && (cls.illegal || cls.aline || cls.fline);
	assign trace_hit = RETIRE && ((TRACE_MODE == TRC_ALL) || (TRACE_MODE == TRC_FLOW && FLOW_CHG));

	// a trace that collides with a decode exception is held until dec_exc drops, not lost
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			trace_pend_ff <= 1'b0;
		end else if (dec_exc && trace_hit) begin
			trace_pend_ff <= 1'b1;
		end else if (!dec_exc) begin
			trace_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			exc_req_ff <= 1'b0;
			exc_vec_ff <= 8'h00;
			bkpt_ff    <= 1'b0;
		end else begin
			exc_req_ff <= dec_exc || trace_hit || trace_pend_ff;
			bkpt_ff    <= DEC_VALID && cls.bkpt;
			if (dec_exc) begin
				if (cls.aline) begin
					exc_vec_ff <= VEC_ALINE;
				end else if (cls.fline) begin
					exc_vec_ff <= VEC_FLINE;
				end else begin
					exc_vec_ff <= VEC_ILLEGAL;
				end
			end else if (trace_hit || trace_pend_ff) begin
				exc_vec_ff <= VEC_TRACE;
			end
		end
	end

	assign EXC_REQ    = exc_req_ff;
	assign EXC_VECTOR = exc_vec_ff;
	assign BKPT_HIT   = bkpt_ff;

	chk_ssw_normal: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		WR_REQ && off_ff == last_ff && info_ff.kind == KIND_NORMAL |-> WR_DATA[15:14] == TPMV_NORMAL)
		else $error("normal frame status word top bits wrong");
	chk_ssw_multi: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		WR_REQ && off_ff == last_ff && info_ff.kind == KIND_MULTI |-> WR_DATA[15:14] == TPMV_MULTI)
		else $error("multi-move status word top bits wrong");
	chk_ssw_exc: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		WR_REQ && off_ff == last_ff && info_ff.kind == KIND_EXC |-> WR_DATA[15:14] == TPMV_EXC)
		else $error("exception-time status word top bits wrong");
	chk_format_code: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		WR_REQ && off_ff == OFF_FMTVEC |-> WR_DATA == {FMT_BUS_FAULT, info_ff.vec_off})
		else $error("format/vector word wrong");
	chk_count_word: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		WR_REQ && WR_ADDR == start_sp_ff - 32'(last_ff) + 32'(OFF_COUNT) - 32'(WORD_BYTES)
		|-> WR_DATA[15:8] == MCODE_REV)
		else $error("transfer count register misplaced");
	chk_upper_byte: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		WR_REQ && off_ff == OFF_FA_LO && info_ff.dyn |-> WR_DATA == info_ff.cyc_addr[15:0])
		else $error("dynamic cycle fault address not upper byte");
	chk_sp_step: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		WR_REQ && WR_ACK && off_ff != OFF_SR |=> WR_REQ && WR_ADDR == $past(WR_ADDR) - 32'(WORD_BYTES))
		else $error("stack pointer not decremented by one word");
	chk_frame_end: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		FRAME_DONE |-> SP_OUT + 32'(last_ff) + 32'(WORD_BYTES) == start_sp_ff && !WR_REQ)
		else $error("final stack pointer wrong");
	chk_illegal_vec: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		DEC_VALID && cls.illegal && !cls.aline && !cls.fline |=> EXC_REQ && EXC_VECTOR == VEC_ILLEGAL)
		else $error("illegal opcode did not raise illegal vector");
	chk_bkpt_range: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		DEC_VALID && DEC_OPCODE >= OP_BKPT_LO && DEC_OPCODE <= OP_BKPT_HI |=> BKPT_HIT && EXC_REQ)
		else $error("breakpoint opcode not trapped");
	chk_line_vec: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		DEC_VALID && DEC_OPCODE[15:12] == LINE_F |=> EXC_VECTOR == VEC_FLINE)
		else $error("line F vector wrong");
	chk_trace_all: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		RETIRE && TRACE_MODE == TRC_ALL && !dec_exc |=> EXC_REQ && EXC_VECTOR == VEC_TRACE)
		else $error("trace exception missing");
	chk_trace_flow: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
		RETIRE && TRACE_MODE == TRC_FLOW && !FLOW_CHG && !dec_exc && !trace_pend_ff |=> !EXC_REQ)
		else $error("flow trace fired without flow change");

	cov_normal: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
		FRAME_DONE && info_ff.kind == KIND_NORMAL);
	cov_multi: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
		FRAME_DONE && info_ff.kind == KIND_MULTI);
	cov_exc_short: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
		FRAME_DONE && info_ff.kind == KIND_EXC && !info_ff.six);
	cov_trace_pend: cover property (@(posedge SYS_CLK) disable iff (!RESETN)
		dec_exc && trace_hit ##1 trace_pend_ff);
endmodule : bffs_stacker

//--- dv/bffs_stack_mem.sv
// stack memory model on the far side of the stack write bus
`timescale 1ns/1ns
module bffs_stack_mem (
	// clock
	input  wire logic        sys_clk,
	// write bus
	input  wire logic        wr_req,
	input  wire logic [31:0] wr_addr,
	input  wire logic [15:0] wr_data,
	output logic             wr_ack,
	// stall setting, cycles before each ack
	input  wire logic [3:0]  dly
);
	logic [15:0] mem [0:63];
	logic [3:0]  cnt_ff;
	initial begin
		wr_ack = 1'b0;
		cnt_ff = 4'h0;
	end
	// ack is a registered pulse, so a slow memory never acks two words at once
	always @(posedge sys_clk) begin
		if (wr_req && wr_ack) begin
			mem[wr_addr[6:1]] <= wr_data;
			wr_ack <= 1'b0;
			cnt_ff <= 4'h0;
		end else if (wr_req && cnt_ff >= dly) begin
			wr_ack <= 1'b1;
		end else if (wr_req) begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
endmodule : bffs_stack_mem

//--- dv/bffs_stacker_tb.sv
// self-checking bench for the bus fault frame stacker
`timescale 1ns/1ns
module bffs_stacker_tb;
	import bffs_pkg::*;
	logic        sys_clk, resetn, fault_valid, busy, wr_req, wr_ack, frame_done;
	logic        dec_valid, dec_undef, retire, flow_chg, exc_req, bkpt_hit;
	logic [31:0] sp_in, wr_addr, sp_out;
	logic [15:0] wr_data, dec_opcode;
	logic [1:0]  trace_mode;
	logic [7:0]  exc_vector;
	logic [3:0]  dly;
	bffs_fault_t fi;
	int          error_cnt, n_tests, cyc_cnt;

	bffs_stacker dut (.SYS_CLK(sys_clk), .RESETN(resetn), .FAULT_VALID(fault_valid), .FAULT_INFO(fi),
		.SP_IN(sp_in), .BUSY(busy), .WR_REQ(wr_req), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_ACK(wr_ack),
		.FRAME_DONE(frame_done), .SP_OUT(sp_out), .DEC_VALID(dec_valid), .DEC_OPCODE(dec_opcode),
		.DEC_UNDEF(dec_undef), .RETIRE(retire), .FLOW_CHG(flow_chg), .TRACE_MODE(trace_mode),
		.EXC_REQ(exc_req), .EXC_VECTOR(exc_vector), .BKPT_HIT(bkpt_hit));
	bffs_stack_mem mem (.sys_clk(sys_clk), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_ack(wr_ack), .dly(dly));

	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one fault frame; a second request is pulsed mid-frame and must be ignored
	task automatic frame(input bffs_kind_t k, input logic six, input logic dyn, input logic [3:0] d);
		logic [15:0] w [0:11];
		logic [31:0] fa, base, a;
		logic [1:0]  tm;
		int          n;
		fa = dyn ? fi.cyc_addr : fi.err_addr;
		tm = k == KIND_NORMAL ? TPMV_NORMAL : k == KIND_MULTI ? TPMV_MULTI : TPMV_EXC;
		n = (k == KIND_EXC && !six) ? 10 : 12;
		w[0] = fi.sr;
		w[1] = fi.ret_pc[31:16];
		w[2] = fi.ret_pc[15:0];
		w[3] = {FMT_BUS_FAULT, fi.vec_off};
		w[4] = fa[31:16];
		w[5] = fa[15:0];
		w[6] = k == KIND_EXC ? fi.pre_sr : fi.fault_data_buffer[31:16];
		w[7] = k == KIND_EXC ? fi.flt_fv : fi.fault_data_buffer[15:0];
		w[8] = fi.cur_pc[31:16];
		w[9] = fi.cur_pc[15:0];
		w[n-2] = {MCODE_REV, k == KIND_MULTI ? fi.xfer_cnt : CNT_NONE};
		w[n-1] = {tm, fi.ssw_lo};
		base = 32'h00000100 - 32'(2 * n);
		// wipe the model so a skipped word cannot pass on an earlier frame's data
		for (int j = 0; j < 64; j++)
			mem.mem[j] = 16'hFFFF;
		@(posedge sys_clk);
		fi.kind <= k;
		fi.six <= six;
		fi.dyn <= dyn;
		dly <= d;
		fault_valid <= 1'b1;
		for (int i = 0; i < 200; i++) begin
			@(posedge sys_clk);
			fault_valid <= (i == 3);
			#1;
			if (frame_done === 1'b1)
				break;
		end
		chk("FRAME_DONE", 1, frame_done);
		chk("SP_OUT", base, sp_out);
		for (int i = 0; i < n; i++) begin
			a = base + 32'(2 * i);
			chk("frame word", w[i], mem.mem[a[6:1]]);
		end
		@(posedge sys_clk);
		#1;
		chk("BUSY", 0, busy);
		repeat (3) @(posedge sys_clk);
		#1;
		chk("WR_REQ", 0, wr_req);
		$display("test frame kind %0d six %0d done", k, six);
	endtask : frame

	task automatic ev(input logic dv, input logic [15:0] op, input logic un, input logic rt, input logic fl,
		input logic [1:0] md, input logic rq, input logic [7:0] vc, input logic bk);
		@(posedge sys_clk);
		dec_valid <= dv;
		dec_opcode <= op;
		dec_undef <= un;
		retire <= rt;
		flow_chg <= fl;
		trace_mode <= md;
		@(posedge sys_clk);
		dec_valid <= 1'b0;
		retire <= 1'b0;
		#1;
		chk("EXC_REQ", rq, exc_req);
		if (rq)
			chk("EXC_VECTOR", vc, exc_vector);
		chk("BKPT_HIT", bk, bkpt_hit);
	endtask : ev

	task t_decode;
		ev(1, 16'h4848, 0, 0, 0, 0, 1, VEC_ILLEGAL, 1);
		ev(1, 16'h484F, 0, 0, 0, 0, 1, VEC_ILLEGAL, 1);
		ev(1, 16'h4847, 0, 0, 0, 0, 0, 8'h00, 0);
		ev(1, 16'h4850, 0, 0, 0, 0, 0, 8'h00, 0);
		ev(1, 16'h1234, 1, 0, 0, 0, 1, VEC_ILLEGAL, 0);
		ev(1, 16'hA123, 0, 0, 0, 0, 1, VEC_ALINE, 0);
		ev(1, 16'hF000, 1, 0, 0, 0, 1, VEC_FLINE, 0);
		$display("test decode done");
	endtask : t_decode

	task t_trace;
		ev(0, 16'h0000, 0, 1, 0, TRC_ALL, 1, VEC_TRACE, 0);
		ev(0, 16'h0000, 0, 1, 0, TRC_FLOW, 0, 8'h00, 0);
		ev(0, 16'h0000, 0, 1, 1, TRC_FLOW, 1, VEC_TRACE, 0);
		ev(0, 16'h0000, 0, 1, 1, 2'h0, 0, 8'h00, 0);
		ev(0, 16'h0000, 0, 1, 1, 2'h3, 0, 8'h00, 0);
		// trace colliding with a breakpoint: decode vector first, trace one cycle later
		ev(1, 16'h4848, 0, 1, 0, TRC_ALL, 1, VEC_ILLEGAL, 1);
		@(posedge sys_clk);
		#1;
		chk("EXC_REQ", 1, exc_req);
		chk("EXC_VECTOR", VEC_TRACE, exc_vector);
		@(posedge sys_clk);
		#1;
		chk("EXC_REQ", 0, exc_req);
		$display("test trace done");
	endtask : t_trace

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		{resetn, fault_valid, dec_valid, dec_undef, retire, flow_chg} = 6'h00;
		{trace_mode, dec_opcode, dly} = '0;
		sp_in = 32'h00000100;
		fi = '{KIND_NORMAL, 1'b0, 1'b0, 16'h2700, 32'h12345678, 12'h008, 32'hAAAA0000, 32'hAAAA0001,
			32'hDDDDEEEE, 32'hCCCC0002, 16'h2004, 16'h0018, 8'h05, 14'h0155};
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		#1;
		chk("BUSY", 0, busy);
		chk("EXC_REQ", 0, exc_req);
		frame(KIND_NORMAL, 0, 1, 4'h0);
		frame(KIND_MULTI, 0, 0, 4'h2);
		frame(KIND_EXC, 1, 0, 4'h1);
		frame(KIND_EXC, 0, 1, 4'h0);
		t_decode();
		t_trace();
		conclude();
	end
endmodule : bffs_stacker_tb
